// ===== hdl/boise_map.svh
/*
  constants for the branch/or/increment/shift execution datapath.
  assumes inclusion by bare name from the package and the modules.
*/
`ifndef BOISE_MAP_SVH
`define BOISE_MAP_SVH
`define BOISE_DATA_W 8
`define BOISE_PC_W 15
`define BOISE_IMM_JMP_W 11
`define BOISE_LATCH_W 7
`define BOISE_LATCH_JMP_HI 6
`define BOISE_LATCH_JMP_LO 3
`define BOISE_DEST_ACC 1'b0
`define BOISE_DEST_FILE 1'b1
`define BOISE_ZERO_BYTE 8'h00
`define BOISE_ONE_BYTE 8'h01
`define BOISE_PC_RESET 15'h0000
`define BOISE_JUMP_CYCLES 2
`endif

// ===== hdl/boise_pkg.sv
/*
  types for the execution datapath: operation select codes.
  assumes boise_map.svh is on the include path.
*/
`include "boise_map.svh"
package boise_pkg;
  typedef enum logic [2:0] {
    boise_op_none,
    boise_op_jump_absolute,
    boise_op_or_literal_acc,
    boise_op_increment_file_reg,
    boise_op_or_acc_file_reg,
    boise_op_shift_left_logical,
    boise_op_shift_right_logical
  } boise_op_t;
  typedef enum logic {
    boise_st_exec,
    boise_st_flush
  } boise_state_t;
endpackage

// ===== hdl/boise_alu.sv
/*
  combinational result and carry for the byte operations; zero is judged in boise_exec.
  assumes operands are stable while op_in names the operation.
*/
`timescale 1ns/1ps
`include "boise_map.svh"
module boise_alu
  import boise_pkg::*;
(
  input wire boise_op_t op_in,
  input wire logic [`BOISE_DATA_W-1:0] acc_in,
  input wire logic [`BOISE_DATA_W-1:0] file_in,
  input wire logic [`BOISE_DATA_W-1:0] literal_in,
  output logic [`BOISE_DATA_W-1:0] result_out,
  output logic carry_out
);
  // per-operation datapath; carry only meaningful for shifts
  always_comb begin
    result_out = `BOISE_ZERO_BYTE;
    carry_out = 1'b0;
    unique case (op_in)
      boise_op_or_literal_acc: result_out = acc_in | literal_in;
      boise_op_increment_file_reg: result_out = file_in + `BOISE_ONE_BYTE;
      boise_op_or_acc_file_reg: result_out = acc_in | file_in;
      boise_op_shift_left_logical: begin
        result_out = {file_in[`BOISE_DATA_W-2:0], 1'b0};
        carry_out = file_in[`BOISE_DATA_W-1];
      end
      boise_op_shift_right_logical: begin
        result_out = {1'b0, file_in[`BOISE_DATA_W-1:1]};
        carry_out = file_in[0];
      end
      default: begin
        result_out = `BOISE_ZERO_BYTE;
        carry_out = 1'b0;
      end
    endcase
  end
endmodule

// ===== hdl/boise_exec.sv
/*
  execution stage for jump, or-literal, increment, or-with-file and logical
  shifts. assumes decode presents op and operands for one cycle with
  op_valid_in and that file_data_in is the addressed register's value.
  the accumulator, flags and write-back port are held here as registers.
*/
`timescale 1ns/1ps
`include "boise_map.svh"
// Summary of operation
// - jump loads immediate into pc 10:0 and latch bits 6:3 into pc 14:11
// - jump takes two cycles; second cycle discards the prefetched instruction
// - jump is unconditional and leaves all status flags untouched
// - or-literal ors accumulator with 8-bit immediate into accumulator, sets zero
// - increment adds one to file register, writes destination, updates zero
// - or-with-file ors accumulator with file register into destination, updates zero
// - destination bit 0 writes accumulator, 1 writes back to the file register
// - left shift: bit 7 to carry, 6:0 to 7:1, zero into bit 0, carry and zero
// - right shift: zero into bit 7, 7:1 to 6:0, bit 0 to carry, carry and zero
module boise_exec
  import boise_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic op_valid_in,
  input wire boise_op_t op_in,
  input wire logic [`BOISE_DATA_W-1:0] literal_in,
  input wire logic [`BOISE_IMM_JMP_W-1:0] jump_target_in,
  input wire logic [`BOISE_LATCH_W-1:0] program_counter_high_latch_in,
  input wire logic dest_sel_in,
  input wire logic [`BOISE_DATA_W-1:0] file_data_in,
  input wire logic carry_in,
  input wire logic zero_in,
  output logic [`BOISE_DATA_W-1:0] acc_out,
  output logic [`BOISE_DATA_W-1:0] file_wdata_out,
  output logic file_we_out,
  output logic carry_out,
  output logic zero_out,
  output logic [`BOISE_PC_W-1:0] pc_out,
  output logic pc_load_out,
  output logic flush_out,
  output logic busy_out
);
  logic [`BOISE_DATA_W-1:0] acc_r;
  logic [`BOISE_DATA_W-1:0] acc_nxt;
  logic [`BOISE_DATA_W-1:0] file_wdata_r;
  logic file_we_r;
  logic file_we_nxt;
  logic carry_r;
  logic carry_nxt;
  logic zero_r;
  logic zero_nxt;
  logic [`BOISE_PC_W-1:0] pc_r;
  logic [`BOISE_PC_W-1:0] pc_nxt;
  logic pc_load_r;
  logic flush_r;
  boise_state_t state_r;
  boise_state_t state_nxt;
  wire logic [`BOISE_DATA_W-1:0] alu_result;
  wire logic alu_carry;

  boise_alu u_alu (
    .op_in(op_in),
    .acc_in(acc_r),
    .file_in(file_data_in),
    .literal_in(literal_in),
    .result_out(alu_result),
    .carry_out(alu_carry)
  );

  // decode of the accepted operation; a flush cycle swallows anything offered
  wire logic take = op_valid_in && (state_r == boise_st_exec);
  wire logic is_jump = take && (op_in == boise_op_jump_absolute);
  wire logic is_orl = take && (op_in == boise_op_or_literal_acc);
  wire logic is_file_op = take && ((op_in == boise_op_increment_file_reg) ||
    (op_in == boise_op_or_acc_file_reg) || (op_in == boise_op_shift_left_logical) ||
    (op_in == boise_op_shift_right_logical));
  wire logic is_shift = take && ((op_in == boise_op_shift_left_logical) ||
    (op_in == boise_op_shift_right_logical));
  wire logic to_file = is_file_op && (dest_sel_in == `BOISE_DEST_FILE);
  wire logic to_acc = is_orl || (is_file_op && (dest_sel_in == `BOISE_DEST_ACC));
  wire logic result_zero = (alu_result == `BOISE_ZERO_BYTE);
  wire logic [`BOISE_PC_W-1:0] jump_pc = {
    program_counter_high_latch_in[`BOISE_LATCH_JMP_HI:`BOISE_LATCH_JMP_LO],
    jump_target_in};

  // next values; flags follow the live inputs unless this op updates them
  always_comb begin
    acc_nxt = to_acc ? alu_result : acc_r;
    file_we_nxt = to_file;
    zero_nxt = (is_orl || is_file_op) ? result_zero : zero_in;
    carry_nxt = is_shift ? alu_carry : carry_in;
    pc_nxt = is_jump ? jump_pc : pc_r;
    state_nxt = is_jump ? boise_st_flush : boise_st_exec;
  end

  // accumulator and write-back port
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_r <= `BOISE_ZERO_BYTE;
      file_wdata_r <= `BOISE_ZERO_BYTE;
      file_we_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      file_wdata_r <= to_file ? alu_result : file_wdata_r;
      file_we_r <= file_we_nxt;
    end
  end

  // status flags; the jump never touches them
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      carry_r <= 1'b0;
      zero_r <= 1'b0;
    end else begin
      carry_r <= carry_nxt;
      zero_r <= zero_nxt;
    end
  end

  // jump sequencing: load pc, then spend one cycle discarding the prefetch
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_r <= `BOISE_PC_RESET;
      pc_load_r <= 1'b0;
      flush_r <= 1'b0;
      state_r <= boise_st_exec;
    end else begin
      pc_r <= pc_nxt;
      pc_load_r <= is_jump;
      flush_r <= is_jump;
      state_r <= state_nxt;
    end
  end

  assign acc_out = acc_r;
  assign file_wdata_out = file_wdata_r;
  assign file_we_out = file_we_r;
  assign carry_out = carry_r;
  assign zero_out = zero_r;
  assign pc_out = pc_r;
  assign pc_load_out = pc_load_r;
  assign flush_out = flush_r;
  // the flush flop and the flush state are set by the same event, so the pin comes off a flop
  assign busy_out = flush_r;

  // checks
  chk_jump_pc_load: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    is_jump |=> pc_load_out && pc_out == {
    $past(program_counter_high_latch_in[`BOISE_LATCH_JMP_HI:`BOISE_LATCH_JMP_LO]),
    $past(jump_target_in)})
    else $error("jump target not loaded");
  chk_jump_two_cycle: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    is_jump |=> flush_out && busy_out ##1 !busy_out)
    else $error("jump not two cycles");
  chk_flush_blocks_op: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    busy_out |=> !file_we_out && $stable(acc_out))
    else $error("flushed instruction executed");
  chk_jump_flags_kept: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    is_jump |=> zero_out == $past(zero_in) && carry_out == $past(carry_in))
    else $error("jump altered flags");
  chk_orl_result: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    is_orl |=> acc_out == ($past(acc_r) | $past(literal_in)))
    else $error("or literal wrong");
  chk_incr_result: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    take && op_in == boise_op_increment_file_reg && dest_sel_in
    |=> file_we_out && file_wdata_out == $past(file_data_in) + `BOISE_ONE_BYTE)
    else $error("increment wrong");
  chk_or_file_acc: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    take && op_in == boise_op_or_acc_file_reg && !dest_sel_in
    |=> !file_we_out && acc_out == ($past(acc_r) | $past(file_data_in)))
    else $error("or with file wrong");
  chk_dest_route: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    is_file_op |=> file_we_out == $past(dest_sel_in))
    else $error("destination routing wrong");
  chk_shl_carry: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    take && op_in == boise_op_shift_left_logical
    |=> carry_out == $past(file_data_in[`BOISE_DATA_W-1]))
    else $error("left shift carry wrong");
  chk_shr_carry: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    take && op_in == boise_op_shift_right_logical && !dest_sel_in
    |=> carry_out == $past(file_data_in[0]) && !acc_out[`BOISE_DATA_W-1])
    else $error("right shift wrong");
  chk_zero_flag: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (is_orl || is_file_op) |=> zero_out == ($past(alu_result) == `BOISE_ZERO_BYTE))
    else $error("zero flag wrong");

  // write-back results, checked from the operands rather than the alu, and what must stay put
  chk_shl_result: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    take && op_in == boise_op_shift_left_logical && dest_sel_in
    |=> file_we_out && file_wdata_out == {$past(file_data_in[`BOISE_DATA_W-2:0]), 1'b0})
    else $error("left shift result wrong");
  chk_shr_result: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    take && op_in == boise_op_shift_right_logical && dest_sel_in
    |=> file_we_out && file_wdata_out == {1'b0, $past(file_data_in[`BOISE_DATA_W-1:1])})
    else $error("right shift result wrong");
  chk_incr_to_acc: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    take && op_in == boise_op_increment_file_reg && !dest_sel_in
    |=> !file_we_out && acc_out == $past(file_data_in) + `BOISE_ONE_BYTE)
    else $error("increment into accumulator wrong");
  chk_or_file_wb: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    take && op_in == boise_op_or_acc_file_reg && dest_sel_in
    |=> file_we_out && $stable(acc_out) &&
    file_wdata_out == ($past(acc_r) | $past(file_data_in)))
    else $error("or with file write-back wrong");
  chk_orl_zero: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    is_orl |=> zero_out == (acc_out == `BOISE_ZERO_BYTE))
    else $error("or literal zero flag wrong");
  chk_flush_flags_kept: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    busy_out |=> zero_out == $past(zero_in) && carry_out == $past(carry_in))
    else $error("flush cycle altered flags");
  chk_flush_no_pulse: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    busy_out |=> !pc_load_out && !flush_out)
    else $error("flush cycle raised a pulse");
  chk_pc_only_jump: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !is_jump |=> $stable(pc_out) && !pc_load_out)
    else $error("pc moved without a jump");
  chk_jump_no_write: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    is_jump |=> !file_we_out && $stable(acc_out))
    else $error("jump wrote data");

  cov_jump: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in) is_jump ##2 take);
  cov_file_write: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in) to_file);
  cov_zero_set: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    is_file_op && result_zero);
  cov_shift_carry: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    is_shift && alu_carry);
  cov_shift_right_file: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    to_file && op_in == boise_op_shift_right_logical);
endmodule

// ===== testbench/boise_decode_model.sv
/* far-side model: addressed file register and flag feedback of the core.
   assumes one addressed register and write-back one cycle after the op. */
`timescale 1ns/1ps
module boise_decode_model (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic file_we_in,
  input wire logic [7:0] file_wdata_in,
  input wire logic carry_in,
  input wire logic zero_in,
  output logic [7:0] file_data_out,
  output logic carry_out,
  output logic zero_out
);
  logic [7:0] file_r;
  // register file entry, written at the edge that ends the write pulse
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) file_r <= 8'h00;
    else if (file_we_in) file_r <= file_wdata_in;
  end
  // no bypass: the op right after a write still reads the old byte, the one after sees it
  assign file_data_out = file_r;
  assign carry_out = carry_in;
  assign zero_out = zero_in;
endmodule

// ===== testbench/branch_or_incr_shift_exec_tb.sv
/* self-checking bench: integer model of the execution stage, checked each op.
   assumes boise_decode_model supplies the file register and flag feedback. */
`timescale 1ns/1ps
module branch_or_incr_shift_exec_tb;
  import boise_pkg::*;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic op_valid_in = 1'b0;
  logic dest_sel_in = 1'b0;
  boise_op_t op_in = boise_op_none;
  logic [7:0] literal_in = 8'h00;
  logic [10:0] jump_target_in = 11'h000;
  logic [6:0] latch_in = 7'h00;
  logic [7:0] file_data, acc, wdata;
  logic we, c_o, z_o, c_i, z_i, pcl, fl, busy;
  logic [14:0] pc;
  int fail_count = 0;
  int n_checks = 0;
  int seed = 32'h0eadd943;
  int macc = 0, mfile = 0, mc = 0, mz = 0, mpc = 0, pend = -1;
  boise_exec boise_exec_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .op_valid_in(op_valid_in), .op_in(op_in), .literal_in(literal_in),
    .jump_target_in(jump_target_in), .program_counter_high_latch_in(latch_in),
    .dest_sel_in(dest_sel_in), .file_data_in(file_data), .carry_in(c_i), .zero_in(z_i),
    .acc_out(acc), .file_wdata_out(wdata), .file_we_out(we), .carry_out(c_o),
    .zero_out(z_o), .pc_out(pc), .pc_load_out(pcl), .flush_out(fl), .busy_out(busy));
  boise_decode_model boise_decode_model_i (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .file_we_in(we), .file_wdata_in(wdata), .carry_in(c_o),
    .zero_in(z_o), .file_data_out(file_data), .carry_out(c_i), .zero_out(z_i));
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk_val(input string what, input logic [14:0] exp, input logic [14:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one op offered at a falling edge, results checked one cycle later;
  // a file write lands too late for the very next op, so the model delays it one op
  task automatic run_op(input boise_op_t op, input logic [7:0] lit, input logic d);
    int src, res, wr;
    logic jmp;
    logic [10:0] tgt;
    logic [6:0] lat;
    tgt = 11'($random(seed));
    lat = 7'($random(seed));
    op_in = op;
    literal_in = lit;
    dest_sel_in = d;
    op_valid_in = 1'b1;
    jump_target_in = tgt;
    latch_in = lat;
    src = mfile;
    if (pend >= 0) mfile = pend;
    pend = -1;
    res = -1;
    jmp = (op == boise_op_jump_absolute);
    case (op)
      boise_op_or_literal_acc: macc = macc | lit;
      boise_op_increment_file_reg: res = (src + 1) & 255;
      boise_op_or_acc_file_reg: res = macc | src;
      boise_op_shift_left_logical: res = (src << 1) & 255;
      boise_op_shift_right_logical: res = src >> 1;
      boise_op_jump_absolute: mpc = {lat[6:3], tgt};
      default: ;
    endcase
    if (op == boise_op_shift_left_logical) mc = src >> 7;
    if (op == boise_op_shift_right_logical) mc = src & 1;
    if (op == boise_op_or_literal_acc) mz = (macc == 0);
    if (res >= 0) mz = (res == 0);
    if (res >= 0 && d) pend = res;
    if (res >= 0 && !d) macc = res;
    wr = (res >= 0 && d);
    @(negedge ref_clk_in);
    chk_val("acc", 15'(macc), 15'(acc));
    chk_bit("zero", 1'(mz), z_o);
    chk_bit("carry", 1'(mc), c_o);
    chk_bit("file_we", 1'(wr), we);
    if (wr) chk_val("file_wdata", 15'(res), 15'(wdata));
    chk_val("pc", 15'(mpc), pc);
    chk_bit("pc_load", jmp, pcl);
    chk_bit("flush", jmp, fl);
    chk_bit("busy", jmp, busy);
    // an op offered in the flush slot must vanish without trace
    if (jmp) begin
      op_in = boise_op_or_literal_acc;
      literal_in = 8'hff;
      @(negedge ref_clk_in);
      chk_val("acc_kept", 15'(macc), 15'(acc));
      chk_bit("busy_end", 1'b0, busy);
      chk_bit("pc_load_end", 1'b0, pcl);
    end
  endtask
  initial begin
    int k;
    repeat (6) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    // corners: all-ones byte wraps to zero, then shifts push ones out of both ends
    run_op(boise_op_or_literal_acc, 8'hff, 1'b0);
    run_op(boise_op_or_acc_file_reg, 8'h00, 1'b1);
    run_op(boise_op_jump_absolute, 8'h00, 1'b0);
    run_op(boise_op_increment_file_reg, 8'h00, 1'b0);
    run_op(boise_op_shift_left_logical, 8'h00, 1'b1);
    run_op(boise_op_shift_right_logical, 8'h00, 1'b0);
    $display("test directed done");
    repeat (400) begin
      k = $random(seed);
      run_op(boise_op_t'(3'((k & 32'h7fff) % 7)), 8'($random(seed)), 1'($random(seed)));
    end
    $display("test random done");
    summarize();
  end
  // about 470 cycles are needed; cut off well beyond that
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule
